// >>> logic/bju_pkg.sv
// Function
// RULE1 - Jumps and branches act after one delay slot
// RULE2 - Implicit links write return address to r31
// RULE3 - Absolute target: PC upper bits, field shifted two
// RULE4 - Absolute link jump stores after-slot address in r31
// RULE5 - Exchange jump links and inverts ISA mode
// RULE6 - Register jump goes to source_reg_a address
// RULE7 - Register link jump writes dest_reg with link
// RULE8 - Branch target: slot address plus shifted offset
// RULE9 - Target formed over two stages, fetched at alu
// RULE10 - False likely branch nullifies its delay slot
// RULE11 - Plain branches always execute the delay slot
// RULE12 - Equal and not-equal register comparisons
// RULE13 - Signed nonpositive and positive tests
// RULE14 - Signed negative and nonnegative tests
// RULE15 - Sign-test links always write r31
// RULE16 - Coprocessor flag branches use 32-bit target
// RULE17 - Likely compare branches discard slot when untaken
// RULE18 - Likely sign-link branches link always, discard
// RULE19 - Likely coprocessor branches discard slot when untaken
// RULE20 - Link value is own address plus eight
// RULE21 - Compressed set enable latched from pin at reset
//
// Purpose: Shared constants, op codes and state layout.
// Assumes: One clock, async active-low reset.
// Notes: Decode of raw encodings happens upstream.
package bju_pkg;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [4:0] BJU_LINK_REG = 5'h1f;
  localparam logic [63:0] BJU_SLOT_OFS = 64'h0000_0000_0000_0004;
  localparam logic [63:0] BJU_LINK_OFS = 64'h0000_0000_0000_0008;
  localparam logic [1:0] BJU_INIT_CAPTURE = 2'h2;
  localparam logic [1:0] BJU_INIT_DONE = 2'h3;

  // ----------------------------------------------------------------
  // Operations delivered by decode
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BJU_OP_NONE, BJU_OP_ABS_GOTO, BJU_OP_ABS_GOTO_WITH_LINK,
    BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE, BJU_OP_REG_GOTO, BJU_OP_REG_GOTO_LINK,
    BJU_OP_BR_IF_SAME, BJU_OP_BR_IF_DIFFER, BJU_OP_BR_IF_NONPOSITIVE,
    BJU_OP_BR_IF_POSITIVE, BJU_OP_BR_IF_NEGATIVE, BJU_OP_BR_IF_NONNEGATIVE,
    BJU_OP_BR_IF_NEGATIVE_LINK, BJU_OP_BR_IF_NONNEGATIVE_LINK,
    BJU_OP_BR_IF_COP_FLAG_SET, BJU_OP_BR_IF_COP_FLAG_CLEAR,
    BJU_OP_BR_IF_SAME_LIKELY, BJU_OP_BR_IF_DIFFER_LIKELY,
    BJU_OP_BR_IF_NONPOSITIVE_LIKELY, BJU_OP_BR_IF_POSITIVE_LIKELY,
    BJU_OP_BR_IF_NEGATIVE_LIKELY, BJU_OP_BR_IF_NONNEGATIVE_LIKELY,
    BJU_OP_BR_IF_NEGATIVE_LINK_LIKELY, BJU_OP_BR_IF_NONNEGATIVE_LINK_LIKELY,
    BJU_OP_BR_IF_COP_FLAG_SET_LIKELY, BJU_OP_BR_IF_COP_FLAG_CLEAR_LIKELY
  } bju_op_e;

  // ----------------------------------------------------------------
  // State of the unit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rf_v;
    bju_op_e rf_op;
    logic rf_m64;
    logic [63:0] rf_slot;
    logic [63:0] rf_link;
    logic [63:0] rf_abs;
    logic [63:0] rf_reg;
    logic [63:0] rf_ofs;
    logic [4:0] rf_dest;
    logic rf_eq;
    logic rf_zero;
    logic rf_neg;
    logic rf_cop;
    logic redir_v;
    logic [63:0] redir_pc;
    logic link_we;
    logic [4:0] link_reg;
    logic [63:0] link_val;
    logic slot_null;
    logic isa_mode;
    logic c16_en;
    logic sync1;
    logic sync2;
    logic [1:0] init_cnt;
  } bju_state_s;

  // ----------------------------------------------------------------
  // Op classification
  // ----------------------------------------------------------------
  function automatic logic bju_is_jump(input bju_op_e op);
    return op inside {BJU_OP_ABS_GOTO, BJU_OP_ABS_GOTO_WITH_LINK,
      BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE, BJU_OP_REG_GOTO,
      BJU_OP_REG_GOTO_LINK};
  endfunction

  function automatic logic bju_is_likely(input bju_op_e op);
    return op >= BJU_OP_BR_IF_SAME_LIKELY;
  endfunction

  function automatic logic bju_is_cop(input bju_op_e op);
    return op inside {BJU_OP_BR_IF_COP_FLAG_SET, BJU_OP_BR_IF_COP_FLAG_CLEAR,
      BJU_OP_BR_IF_COP_FLAG_SET_LIKELY, BJU_OP_BR_IF_COP_FLAG_CLEAR_LIKELY};
  endfunction

  // Ops that write a link register
  function automatic logic bju_links(input bju_op_e op);
    return op inside {BJU_OP_ABS_GOTO_WITH_LINK,
      BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE, BJU_OP_REG_GOTO_LINK,
      BJU_OP_BR_IF_NEGATIVE_LINK, BJU_OP_BR_IF_NONNEGATIVE_LINK,
      BJU_OP_BR_IF_NEGATIVE_LINK_LIKELY,
      BJU_OP_BR_IF_NONNEGATIVE_LINK_LIKELY};
  endfunction

  function automatic logic [63:0] bju_sext32(input logic [63:0] v);
    return {{32{v[31]}}, v[31:0]};
  endfunction

endpackage : bju_pkg

// >>> logic/bju_cond_if.sv
// Purpose: Carries operand values and comparison flags.
// Assumes: Purely combinational between two modules.
// Notes: No clock; the owner registers the flags.
interface bju_cond_if;
  logic [63:0] a_val;
  logic [63:0] b_val;
  logic m64;
  logic eq;
  logic zero;
  logic neg;

  modport eval (input a_val, input b_val, input m64,
    output eq, output zero, output neg);
  modport user (output a_val, output b_val, output m64,
    input eq, input zero, input neg);
endinterface : bju_cond_if

// >>> logic/bju_cond_eval.sv
// Purpose: Equality and sign flags of the branch operands.
// Assumes: Operands come from the register read port.
// Notes: In 32-bit mode only the low word is looked at.
module bju_cond_eval
  import bju_pkg::*;
(
  bju_cond_if.eval cif
);

  // ----------------------------------------------------------------
  // Flag evaluation
  // ----------------------------------------------------------------
  // Narrow mode ignores the upper word, which may hold stale bits
  always_comb begin
    if (cif.m64) begin
      cif.eq = (cif.a_val == cif.b_val); // RULE12
      cif.zero = (cif.a_val == 64'h0000_0000_0000_0000);
      cif.neg = cif.a_val[63]; // RULE14
    end else begin
      cif.eq = (cif.a_val[31:0] == cif.b_val[31:0]); // RULE12
      cif.zero = (cif.a_val[31:0] == 32'h0000_0000);
      cif.neg = cif.a_val[31]; // RULE14
    end
  end

endmodule // bju_cond_eval

// >>> logic/bju_branch_unit.sv
// Purpose: Resolves jumps and branches, drives fetch redirect and link.
// Assumes: Decode presents one op per enabled cycle in operand read.
// Notes: Redirect appears two enabled cycles after the op enters operand read.
module bju_branch_unit
  import bju_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic compressed_isa_enable_pin,
  input wire logic mode64,
  input wire logic op_valid,
  input wire bju_op_e op_code,
  input wire logic [63:0] op_pc,
  input wire logic [25:0] target26,
  input wire logic [15:0] offset16,
  input wire logic [4:0] dest_reg,
  input wire logic [63:0] src_a_val,
  input wire logic [63:0] src_b_val,
  input wire logic cop0_cond,
  output logic redirect_valid,
  output logic [63:0] redirect_pc,
  output logic link_we,
  output logic [4:0] link_reg,
  output logic [63:0] link_value,
  output logic slot_nullify,
  output logic isa_mode,
  output logic compressed_isa_enabled
);

  // ----------------------------------------------------------------
  // State and carrier
  // ----------------------------------------------------------------
  bju_state_s st_q;
  bju_state_s st_d;
  logic taken;
  logic [63:0] br_tgt;
  logic [63:0] cop_tgt;
  logic [63:0] jmp_tgt;
  logic [31:0] cop_sum;

  bju_cond_if cif ();

  // Operands go straight to the comparator during operand read
  assign cif.a_val = src_a_val;
  assign cif.b_val = src_b_val;
  assign cif.m64 = mode64;

  bju_cond_eval u_cond (
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // Branch condition of the op in the alu stage
  // ----------------------------------------------------------------
  // Likely forms share the test of their plain forms
  always_comb begin
    taken = 1'b0;
    case (st_q.rf_op)
      BJU_OP_BR_IF_SAME,
      BJU_OP_BR_IF_SAME_LIKELY: taken = st_q.rf_eq; // RULE12 RULE17
      BJU_OP_BR_IF_DIFFER,
      BJU_OP_BR_IF_DIFFER_LIKELY: taken = !st_q.rf_eq; // RULE12 RULE17
      BJU_OP_BR_IF_NONPOSITIVE,
      BJU_OP_BR_IF_NONPOSITIVE_LIKELY: begin
        taken = st_q.rf_neg || st_q.rf_zero; // RULE13 RULE17
      end
      BJU_OP_BR_IF_POSITIVE,
      BJU_OP_BR_IF_POSITIVE_LIKELY: begin
        taken = !st_q.rf_neg && !st_q.rf_zero; // RULE13 RULE17
      end
      BJU_OP_BR_IF_NEGATIVE,
      BJU_OP_BR_IF_NEGATIVE_LIKELY,
      BJU_OP_BR_IF_NEGATIVE_LINK,
      BJU_OP_BR_IF_NEGATIVE_LINK_LIKELY: begin
        taken = st_q.rf_neg; // RULE14 RULE15 RULE18
      end
      BJU_OP_BR_IF_NONNEGATIVE,
      BJU_OP_BR_IF_NONNEGATIVE_LIKELY,
      BJU_OP_BR_IF_NONNEGATIVE_LINK,
      BJU_OP_BR_IF_NONNEGATIVE_LINK_LIKELY: begin
        taken = !st_q.rf_neg; // RULE14 RULE15 RULE18
      end
      BJU_OP_BR_IF_COP_FLAG_SET,
      BJU_OP_BR_IF_COP_FLAG_SET_LIKELY: taken = st_q.rf_cop; // RULE16 RULE19
      BJU_OP_BR_IF_COP_FLAG_CLEAR,
      BJU_OP_BR_IF_COP_FLAG_CLEAR_LIKELY: begin
        taken = !st_q.rf_cop; // RULE16 RULE19
      end
      default: taken = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Target selection in the alu stage
  // ----------------------------------------------------------------
  // Second half of the target sum; the first half ran in operand read
  always_comb begin
    br_tgt = st_q.rf_slot + st_q.rf_ofs; // RULE8 RULE9
    cop_sum = st_q.rf_slot[31:0] + st_q.rf_ofs[31:0]; // RULE16 RULE19
    cop_tgt = {{32{cop_sum[31]}}, cop_sum};
    case (st_q.rf_op)
      BJU_OP_ABS_GOTO,
      BJU_OP_ABS_GOTO_WITH_LINK,
      BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE: jmp_tgt = st_q.rf_abs; // RULE3
      BJU_OP_REG_GOTO,
      BJU_OP_REG_GOTO_LINK: jmp_tgt = st_q.rf_reg; // RULE6 RULE7
      default: begin
        if (bju_is_cop(st_q.rf_op)) begin
          jmp_tgt = cop_tgt;
        end else begin
          jmp_tgt = br_tgt;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Strap pin crossing; only the second stage is ever read
    st_d.sync1 = compressed_isa_enable_pin;
    st_d.sync2 = st_q.sync1;

    // Strap capture once the crossing holds a post-reset sample
    if (st_q.init_cnt != BJU_INIT_DONE) begin
      st_d.init_cnt = st_q.init_cnt + 2'h1;
      if (st_q.init_cnt == BJU_INIT_CAPTURE) begin
        st_d.c16_en = st_q.sync2; // RULE21
      end
    end

    // Operand read stage: first half of every target
    st_d.rf_v = op_valid;
    st_d.rf_op = op_code;
    st_d.rf_m64 = mode64;
    st_d.rf_slot = op_pc + BJU_SLOT_OFS; // RULE8 RULE9
    st_d.rf_link = op_pc + BJU_LINK_OFS; // RULE20
    st_d.rf_abs = {op_pc[63:28], target26, 2'b00}; // RULE3
    st_d.rf_reg = src_a_val; // RULE6
    st_d.rf_ofs = {{46{offset16[15]}}, offset16, 2'b00}; // RULE8
    st_d.rf_dest = dest_reg;
    st_d.rf_eq = cif.eq;
    st_d.rf_zero = cif.zero;
    st_d.rf_neg = cif.neg;
    st_d.rf_cop = cop0_cond;

    // Alu stage: fetch redirect after the slot already in flight
    st_d.redir_v = st_q.rf_v && (bju_is_jump(st_q.rf_op) || taken); // RULE1
    if (st_q.rf_m64) begin
      st_d.redir_pc = jmp_tgt;
      st_d.link_val = st_q.rf_link; // RULE20
    end else begin
      st_d.redir_pc = bju_sext32(jmp_tgt);
      st_d.link_val = bju_sext32(st_q.rf_link); // RULE20
    end

    // Link written whether the branch is taken or not
    st_d.link_we = st_q.rf_v && bju_links(st_q.rf_op); // RULE2 RULE4 RULE15
    if (st_q.rf_op == BJU_OP_REG_GOTO_LINK) begin
      st_d.link_reg = st_q.rf_dest; // RULE7
    end else begin
      st_d.link_reg = BJU_LINK_REG; // RULE2 RULE18
    end

    // Plain forms keep the slot; failing likely forms kill it
    st_d.slot_null = st_q.rf_v && bju_is_likely(st_q.rf_op)
      && !taken; // RULE10 RULE11 RULE17 RULE18 RULE19

    // Mode flip is refused while the compressed set is disabled
    if (st_q.rf_v && st_q.rf_op == BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE
        && st_q.c16_en) begin
      st_d.isa_mode = !st_q.isa_mode; // RULE5 RULE21
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Enable low freezes the pipeline, strap crossing included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (en) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign redirect_valid = st_q.redir_v;
  assign redirect_pc = st_q.redir_pc;
  assign link_we = st_q.link_we;
  assign link_reg = st_q.link_reg;
  assign link_value = st_q.link_val;
  assign slot_nullify = st_q.slot_null;
  assign isa_mode = st_q.isa_mode;
  assign compressed_isa_enabled = st_q.c16_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A jump redirects fetch exactly two enabled cycles after operand read
  property p_slot_delay;
    (en && op_valid && bju_is_jump(op_code)) ##1 en |=>
      redirect_valid;
  endproperty
  a_slot_delay: assert property (p_slot_delay) // RULE1
    else $error("jump did not redirect after the delay slot");

  // Absolute link jump writes r31
  property p_abs_link_r31;
    (en && op_valid && op_code == BJU_OP_ABS_GOTO_WITH_LINK) ##1 en |=>
      link_we && link_reg == 5'h1f;
  endproperty
  a_abs_link_r31: assert property (p_abs_link_r31) // RULE4
    else $error("absolute link jump did not write r31");

  // Absolute target low part is the field shifted by two
  property p_abs_tgt;
    (en && op_valid && op_code == BJU_OP_ABS_GOTO) ##1 en |=>
      redirect_pc[27:0] == {$past(target26, 2), 2'b00};
  endproperty
  a_abs_tgt: assert property (p_abs_tgt) // RULE3
    else $error("absolute target field wrong");

  // Exchange jump flips the mode when the set is enabled
  property p_isa_toggle;
    (en && op_valid && op_code == BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE
      && compressed_isa_enabled) ##1 en |=>
      isa_mode != $past(isa_mode) && link_reg == 5'h1f;
  endproperty
  a_isa_toggle: assert property (p_isa_toggle) // RULE5
    else $error("exchange jump did not flip mode");

  // Register jump in wide mode goes to the operand value
  property p_reg_tgt;
    (en && op_valid && mode64 && op_code == BJU_OP_REG_GOTO) ##1 en |=>
      redirect_valid && redirect_pc == $past(src_a_val, 2);
  endproperty
  a_reg_tgt: assert property (p_reg_tgt) // RULE6
    else $error("register jump target wrong");

  // Register link jump names its own destination
  property p_rgl_dest;
    (en && op_valid && op_code == BJU_OP_REG_GOTO_LINK) ##1 en |=>
      link_we && link_reg == $past(dest_reg, 2);
  endproperty
  a_rgl_dest: assert property (p_rgl_dest) // RULE7
    else $error("register link destination wrong");

  // Link value is own address plus eight in wide mode
  property p_link_val;
    (en && op_valid && mode64 && bju_links(op_code)) ##1 en |=>
      link_value == $past(op_pc, 2) + 64'h0000_0000_0000_0008;
  endproperty
  a_link_val: assert property (p_link_val) // RULE20
    else $error("link value not pc plus eight");

  // A nullified slot never goes with a redirect
  property p_likely_null;
    slot_nullify |-> !redirect_valid;
  endproperty
  a_likely_null: assert property (p_likely_null) // RULE10
    else $error("nullified slot on a taken branch");

  // Plain branches never kill their slot
  property p_plain_exec;
    (en && op_valid && !bju_is_likely(op_code)) ##1 en |=> !slot_nullify;
  endproperty
  a_plain_exec: assert property (p_plain_exec) // RULE11
    else $error("plain branch nullified its slot");

  // Equal operands take the equal branch
  property p_same;
    (en && op_valid && op_code == BJU_OP_BR_IF_SAME
      && src_a_val == src_b_val) ##1 en |=> redirect_valid;
  endproperty
  a_same: assert property (p_same) // RULE12
    else $error("equal branch not taken");

  // Sign-test link always links, taken or not
  property p_sign_link;
    (en && op_valid && op_code == BJU_OP_BR_IF_NEGATIVE_LINK) ##1 en |=>
      link_we && link_reg == 5'h1f;
  endproperty
  a_sign_link: assert property (p_sign_link) // RULE15
    else $error("sign-test link did not write r31");

  // Mode stays normal while the compressed set is off
  property p_c16_gate;
    !compressed_isa_enabled |-> !isa_mode;
  endproperty
  a_c16_gate: assert property (p_c16_gate) // RULE21
    else $error("mode flipped with compressed set off");

  // Failing likely branch kills its slot and does not redirect
  property p_likely_kill;
    (en && op_valid && op_code == BJU_OP_BR_IF_DIFFER_LIKELY
      && src_a_val == src_b_val) ##1 en |=>
      slot_nullify && !redirect_valid;
  endproperty
  a_likely_kill: assert property (p_likely_kill) // RULE10
    else $error("failing likely branch kept its slot");

  // Coprocessor target is a 32-bit sum, sign-extended
  property p_cop_tgt;
    (en && op_valid && op_code == BJU_OP_BR_IF_COP_FLAG_SET && cop0_cond)
      ##1 en |=> redirect_valid
      && redirect_pc[63:32] == {32{redirect_pc[31]}};
  endproperty
  a_cop_tgt: assert property (p_cop_tgt) // RULE16
    else $error("coprocessor target not 32-bit extended");

  // Zero operand takes the nonpositive branch
  property p_nonpos;
    (en && op_valid && op_code == BJU_OP_BR_IF_NONPOSITIVE
      && src_a_val == 64'h0000_0000_0000_0000) ##1 en |=> redirect_valid;
  endproperty
  a_nonpos: assert property (p_nonpos) // RULE13
    else $error("nonpositive branch not taken on zero");

  // Wide-mode branch target is slot address plus shifted offset
  property p_branch_tgt;
    (en && op_valid && mode64 && op_code == BJU_OP_BR_IF_SAME
      && src_a_val == src_b_val) ##1 en |=> redirect_pc ==
      $past(op_pc, 2) + 64'h0000_0000_0000_0004
      + (64'($signed($past(offset16, 2))) << 2);
  endproperty
  a_branch_tgt: assert property (p_branch_tgt) // RULE8
    else $error("branch target wrong");

  // Likely sign-link form links to r31 whatever the outcome
  property p_link_likely;
    (en && op_valid && op_code == BJU_OP_BR_IF_NONNEGATIVE_LINK_LIKELY)
      ##1 en |=> link_we && link_reg == 5'h1f;
  endproperty
  a_link_likely: assert property (p_link_likely) // RULE18
    else $error("likely sign-link branch did not write r31");

  // Likely coprocessor branch with a failing test kills its slot
  property p_cop_likely;
    (en && op_valid && op_code == BJU_OP_BR_IF_COP_FLAG_CLEAR_LIKELY
      && cop0_cond) ##1 en |=> slot_nullify && !redirect_valid;
  endproperty
  a_cop_likely: assert property (p_cop_likely) // RULE19
    else $error("likely coprocessor branch kept its slot");

endmodule // bju_branch_unit

// >>> dv/test_branch_jump_unit.sv
// Purpose: Self-checking bench for the branch and jump unit.
// Assumes: Results land two enabled edges after an op is taken.
// Notes: Fixed-seed random ops, plus corner operands for every op.
module test_branch_jump_unit
  import bju_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic pin = 1'b1;
  logic m64 = 1'b1;
  logic vld = 1'b0;
  bju_op_e op = BJU_OP_NONE;
  logic [63:0] pc = 64'h0000_0000_0000_0000;
  logic [63:0] a = 64'h0000_0000_0000_0000;
  logic [63:0] b = 64'h0000_0000_0000_0000;
  logic [25:0] t26 = 26'h000_0000;
  logic [15:0] o16 = 16'h0000;
  logic [4:0] dr = 5'h00;
  logic cop = 1'b0;
  logic rv, lw, sn, isa, c16;
  logic [63:0] rpc, lv;
  logic [4:0] lr;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed_v;
  logic [63:0] r;

  typedef struct packed {
    logic rv;
    logic [63:0] pc;
    logic lw;
    logic [4:0] lr;
    logic [63:0] lv;
    logic sn;
    logic tg;
  } bju_tb_exp_s;

  bju_tb_exp_s st1, st2;
  logic tb_isa, tb_c16;
  int init_n;

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  bju_branch_unit u_bju_branch_unit (
    .clk(clk), .rst_n(rst_n), .en(en), .compressed_isa_enable_pin(pin),
    .mode64(m64), .op_valid(vld), .op_code(op), .op_pc(pc),
    .target26(t26), .offset16(o16), .dest_reg(dr), .src_a_val(a),
    .src_b_val(b), .cop0_cond(cop), .redirect_valid(rv),
    .redirect_pc(rpc), .link_we(lw), .link_reg(lr), .link_value(lv),
    .slot_nullify(sn), .isa_mode(isa), .compressed_isa_enabled(c16)
  );

  // ------------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------------
  function automatic logic [63:0] sx(input logic [63:0] v);
    return {{32{v[31]}}, v[31:0]};
  endfunction

  function automatic bju_tb_exp_s expect_f(input bju_op_e o,
      input logic [63:0] p, pa, pb, input logic [25:0] t,
      input logic [15:0] f, input logic [4:0] d, input logic c, wide);
    bju_tb_exp_s e;
    logic [63:0] av, slot, bt;
    logic eq, ng, zr, tk;
    e = '0;
    av = wide ? pa : sx(pa);
    eq = wide ? (pa == pb) : (pa[31:0] == pb[31:0]);
    ng = av[63];
    zr = (av == 64'h0000_0000_0000_0000);
    slot = p + 64'h0000_0000_0000_0004;
    bt = slot + {{46{f[15]}}, f, 2'b00};
    tk = 1'b1;
    case (o)
      BJU_OP_ABS_GOTO, BJU_OP_ABS_GOTO_WITH_LINK,
      BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE: bt = {p[63:28], t, 2'b00};
      BJU_OP_REG_GOTO, BJU_OP_REG_GOTO_LINK: bt = pa;
      BJU_OP_BR_IF_SAME, BJU_OP_BR_IF_SAME_LIKELY: tk = eq;
      BJU_OP_BR_IF_DIFFER, BJU_OP_BR_IF_DIFFER_LIKELY: tk = !eq;
      BJU_OP_BR_IF_NONPOSITIVE, BJU_OP_BR_IF_NONPOSITIVE_LIKELY: tk = ng | zr;
      BJU_OP_BR_IF_POSITIVE, BJU_OP_BR_IF_POSITIVE_LIKELY: tk = !ng & !zr;
      BJU_OP_BR_IF_NEGATIVE, BJU_OP_BR_IF_NEGATIVE_LINK,
      BJU_OP_BR_IF_NEGATIVE_LIKELY,
      BJU_OP_BR_IF_NEGATIVE_LINK_LIKELY: tk = ng;
      BJU_OP_BR_IF_NONNEGATIVE, BJU_OP_BR_IF_NONNEGATIVE_LINK,
      BJU_OP_BR_IF_NONNEGATIVE_LIKELY,
      BJU_OP_BR_IF_NONNEGATIVE_LINK_LIKELY: tk = !ng;
      BJU_OP_BR_IF_COP_FLAG_SET, BJU_OP_BR_IF_COP_FLAG_SET_LIKELY: tk = c;
      BJU_OP_BR_IF_COP_FLAG_CLEAR,
      BJU_OP_BR_IF_COP_FLAG_CLEAR_LIKELY: tk = !c;
      default: tk = 1'b0;
    endcase
    // Coprocessor targets wrap at 32 bits, whatever the mode
    if (o inside {BJU_OP_BR_IF_COP_FLAG_SET, BJU_OP_BR_IF_COP_FLAG_CLEAR,
        BJU_OP_BR_IF_COP_FLAG_SET_LIKELY,
        BJU_OP_BR_IF_COP_FLAG_CLEAR_LIKELY}) begin
      bt = sx({32'h0000_0000, slot[31:0] + {{14{f[15]}}, f, 2'b00}});
    end
    e.rv = tk;
    e.pc = wide ? bt : sx(bt);
    e.lw = o inside {BJU_OP_ABS_GOTO_WITH_LINK, BJU_OP_REG_GOTO_LINK,
      BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE, BJU_OP_BR_IF_NEGATIVE_LINK,
      BJU_OP_BR_IF_NONNEGATIVE_LINK, BJU_OP_BR_IF_NEGATIVE_LINK_LIKELY,
      BJU_OP_BR_IF_NONNEGATIVE_LINK_LIKELY};
    e.lr = (o == BJU_OP_REG_GOTO_LINK) ? d : 5'h1f;
    e.lv = wide ? p + 64'h0000_0000_0000_0008 :
      sx(p + 64'h0000_0000_0000_0008);
    e.sn = (o >= BJU_OP_BR_IF_SAME_LIKELY) && !tk;
    e.tg = (o == BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE);
    return e;
  endfunction

  // Two-stage expectation pipe; en low freezes it like the unit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st1 <= '0;
      st2 <= '0;
      tb_isa <= 1'b0;
      tb_c16 <= 1'b0;
      init_n <= 0;
    end else if (en) begin
      st1 <= vld ? expect_f(op, pc, a, b, t26, o16, dr, cop, m64) : '0;
      st2 <= st1;
      if (init_n < 3) init_n <= init_n + 1;
      if (init_n == 2) tb_c16 <= pin;
      if (st1.tg && tb_c16) tb_isa <= !tb_isa;
    end
  end

  // ------------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Outputs are registered, so the falling edge sees them settled
  always @(negedge clk) begin
    chk("redirect_valid", st2.rv, rv);
    if (st2.rv === 1'b1) chk("redirect_pc", st2.pc, rpc);
    chk("link_we", st2.lw, lw);
    if (st2.lw === 1'b1) chk("link_reg", st2.lr, lr);
    if (st2.lw === 1'b1) chk("link_value", st2.lv, lv);
    chk("slot_nullify", st2.sn, sn);
    chk("isa_mode", tb_isa, isa);
    chk("compressed_isa_enabled", tb_c16, c16);
  end

  // Hang guard, well above the roughly one thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      $display("wrong value cycle limit expected %0d seen %0d", 7999, cyc);
      final_report;
    end
  end

  // ------------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------------
  task automatic put(input bju_op_e o, input logic [63:0] va, vb,
      input logic [15:0] f, input logic c);
    logic [63:0] p;
    p = {$urandom, $urandom} & 64'hffff_ffff_ffff_fffc;
    @(negedge clk);
    vld = 1'b1;
    op = o;
    a = va;
    b = vb;
    o16 = f;
    cop = c;
    pc = m64 ? p : sx(p);
    t26 = 26'($urandom);
    dr = 5'($urandom);
  endtask

  task automatic reset_unit(input logic strap);
    // Falling edge, after that edge's checks have sampled
    @(negedge clk);
    rst_n <= 1'b0;
    vld = 1'b0;
    en = 1'b1;
    pin = strap;
    repeat (4) @(negedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    seed_v = $urandom(38);
    reset_unit(1'b1);
    // Every op, both modes, zero and word-boundary operands
    for (int m = 0; m < 2; m++) begin
      m64 = m[0];
      for (int k = 0; k < 26; k++) begin
        put(bju_op_e'(k), 64'h0, 64'h0, 16'h8000, 1'b1);
        put(bju_op_e'(k), 64'h8000_0000, 64'h1_8000_0000, 16'h7fff,
          1'b0);
        put(bju_op_e'(k), 64'hffff_ffff_ffff_ffff, 64'h1, 16'h0001,
          1'b1);
      end
    end
    // Random traffic with stalls from en
    for (int i = 0; i < 800; i++) begin
      r = {$urandom, $urandom};
      m64 = 1'($urandom);
      en = ($urandom_range(7) != 0);
      put(bju_op_e'($urandom_range(25)), r,
        ($urandom_range(3) == 0) ? r : {$urandom, $urandom},
        16'($urandom), 1'($urandom));
    end
    // Strap low: exchange jump still links but keeps the mode
    reset_unit(1'b0);
    put(BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE, 64'h0, 64'h0, 16'h0, 1'b0);
    put(BJU_OP_ABS_GOTO_LINK_ISA_TOGGLE, 64'h0, 64'h0, 16'h0, 1'b1);
    @(negedge clk);
    vld = 1'b0;
    repeat (6) @(negedge clk);
    final_report;
  end

endmodule // test_branch_jump_unit
